// ---- rtl/wdg_top.sv ----
// Watchdog timer with AHB-Lite register access and stop control
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module wdg_top
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        activation_option,
  input  wire logic        stop_control_option,
  input  wire logic        nmi_pin,
  input  wire logic        stop_request,
  output logic             stop_enter,
  output logic             wait_enter,
  output logic             wdg_reset_n,
  output logic             hw_active
);
  import wdg_pkg::*;

  // Strap is caught once after release, never under the async reset
  logic       strap_hw;
  logic       strap_taken;
  logic       act;
  logic [6:0] count;
  logic [WDG_DIV_W-1:0] div;
  logic       wr_pend;
  logic [31:0] wr_addr;
  logic       nmi_level;
  logic       frozen;
  wdg_power_e power;
  wdg_power_e next_power;

  wdg_sync u_nmi_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     (nmi_pin),
    .level   (nmi_level)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_hw    <= 1'b0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      strap_hw    <= activation_option;  // see [RULE_01]
      strap_taken <= 1'b1;
    end
  end

  // Bus decode
  wire addr_phase = hsel && hready && (htrans == WDG_HTRANS_NONSEQ || htrans == WDG_HTRANS_SEQ);
  wire wr_take    = addr_phase && hwrite;
  wire wr_hit     = wr_pend && (wr_addr == WDG_ADDR_TIMEOUT);
  wire rd_hit     = addr_phase && !hwrite && (haddr == WDG_ADDR_TIMEOUT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= wr_take;
      wr_addr <= haddr;
    end
  end

  // Written value, with countdown bits unreversed into counter order
  wire [5:0] wr_t;
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_rev
      assign wr_t[gi] = hwdata[7 - gi];  // see [RULE_16]
    end
  endgenerate
  wire [6:0] wr_count  = {hwdata[WDG_BIT_SR], wr_t};
  // Constant, so the async reset branch loads a literal value
  localparam logic [6:0] WDG_CNT_RESET = {WDG_RESET_VALUE[WDG_BIT_SR], WDG_RESET_VALUE[2], WDG_RESET_VALUE[3],
                                          WDG_RESET_VALUE[4], WDG_RESET_VALUE[5], WDG_RESET_VALUE[6],
                                          WDG_RESET_VALUE[7]};

  // Activation: hardware strap forces it, software may only set it
  wire active    = act || (strap_taken && strap_hw);  // see [RULE_02]
  wire next_act  = act || (wr_hit && hwdata[WDG_BIT_ACT]);  // see [RULE_04] [RULE_05]
  wire tick      = (div == WDG_DIV_LAST);
  wire run_count = !frozen;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div <= '0;
    end else begin
      // Free-running; bus writes do not restart it, see [RULE_21]
      div <= tick ? '0 : div + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act   <= WDG_RESET_VALUE[WDG_BIT_ACT];  // see [RULE_17]
      count <= WDG_CNT_RESET;
    end else begin
      act <= next_act;
      if (wr_hit) begin
        count <= wr_count;  // see [RULE_07]
      end else if (tick && run_count) begin
        // Wraps freely when inactive so it serves as a timer; see [RULE_06] [RULE_13] [RULE_10]
        count <= count - 7'h01;
      end
    end
  end

  // Reset when active and soft-reset bit is zero, counted or written
  wire sr_zero   = !count[6];
  wire sw_reset  = wr_hit && !hwdata[WDG_BIT_SR] && (active || hwdata[WDG_BIT_ACT]);  // see [RULE_11]
  wire trig      = (active && sr_zero) || sw_reset;  // see [RULE_08]

  wdg_pulse u_pulse (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .trigger   (trig),
    .rst_out_n (wdg_reset_n)
  );

  // Stop handling
  always_comb begin
    next_power = power;
    case (power)
      WDG_RUN: begin
        if (stop_request) begin
          if (!active) begin
            next_power = WDG_STOP;
          end else if (!stop_control_option) begin
            next_power = WDG_WAIT;  // see [RULE_18]
          end else if (nmi_level) begin
            next_power = WDG_STOP;  // see [RULE_19]
          end else begin
            next_power = WDG_WAIT;  // see [RULE_19]
          end
        end
      end
      WDG_WAIT: begin
        if (!stop_request) begin
          next_power = WDG_RUN;
        end
      end
      WDG_STOP: begin
        if (!stop_request) begin
          next_power = WDG_RUN;
        end
      end
      default: begin
        next_power = WDG_RUN;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power <= WDG_RUN;
    end else begin
      power <= next_power;
    end
  end

  assign frozen     = (power == WDG_STOP);
  assign stop_enter = (power == WDG_STOP);
  assign wait_enter = (power == WDG_WAIT);
  assign hw_active  = active;

  // Read data registered in the address phase, returned in the data phase
  wire [7:0] rd_val = {count[0], count[1], count[2], count[3], count[4], count[5], count[6], active};
  // Under the hardware option bit 0 reads as one, which is one of the allowed values; see [RULE_03]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (rd_hit) begin
      hrdata <= {24'h000000, rd_val};
    end else if (addr_phase) begin
      hrdata <= '0;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  logic unused_hsize;
  assign unused_hsize = ^hsize;
endmodule
`default_nettype wire

// ---- rtl/wdg_pkg.sv ----
// Constants and types shared by the watchdog design files
// How it works
// [RULE_01] A strap selects hardware or software watchdog activation.
// [RULE_02] Hardware option: active from reset, activate bit held one, writes ignored.
// [RULE_03] Hardware option: activate bit reads back as either value; do not rely on it.
// [RULE_04] Software option: inactive after reset, activated by writing activate bit one.
// [RULE_05] Once activated by software, clearing the activate bit is ignored until reset.
// [RULE_06] Seven-bit counter decrements once every 3072 core clocks.
// [RULE_07] Timeout programmable in 64 steps of one decrement interval.
// [RULE_08] Active watchdog with soft-reset bit zero starts a reset pulse.
// [RULE_09] Software reloads the register with FEh down to 02h periodically.
// [RULE_10] At 8 MHz, FEh gives 24.576 ms and 02h gives 0.384 ms.
// [RULE_11] Writing soft-reset bit zero while active causes an immediate reset.
// [RULE_12] Software sets activate, keeps soft-reset one, loads countdown bits.
// [RULE_13] Inactive with software option, counter runs as a plain 7-bit timer.
// [RULE_14] System holds stop pin high by default, low while protection needed.
// [RULE_15] Timer users test activate bit and force reset if it is set.
// [RULE_16] Countdown bits reversed: bit 7 is counter LSB, bit 2 its MSB.
// [RULE_17] Register at 0D8h, resets to FEh.
// [RULE_18] Active, stop control off: stop request behaves as wait.
// [RULE_19] Active, stop control on: pin high freezes and stops; pin low acts as wait.
// [RULE_20] Reset pulse is a fixed cycle count near 500 ns.
// [RULE_21] Decrement divider free-runs from reset; writes never restart it.
package wdg_pkg;
  localparam int          WDG_CLK_MHZ       = 125;
  localparam int          WDG_DIV_CYCLES    = 3072;
  localparam int          WDG_PULSE_NS      = 500;
  localparam int          WDG_PULSE_CYCLES  = (WDG_PULSE_NS * WDG_CLK_MHZ) / 1000;
  localparam int          WDG_DIV_W         = 12;
  localparam int          WDG_PULSE_W       = 7;
  localparam logic [31:0] WDG_IDX_TIMEOUT   = 32'h0000_00D8;
  localparam logic [31:0] WDG_ADDR_TIMEOUT  = WDG_IDX_TIMEOUT << 2;  // One word per register index
  localparam logic [7:0]  WDG_RESET_VALUE   = 8'hFE;
  localparam int          WDG_BIT_ACT       = 0;
  localparam int          WDG_BIT_SR        = 1;
  localparam logic [1:0]  WDG_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  WDG_HTRANS_SEQ    = 2'h3;
  localparam logic [2:0]  WDG_HSIZE_WORD    = 3'h2;
  localparam logic [WDG_DIV_W-1:0]   WDG_DIV_LAST   = WDG_DIV_W'(WDG_DIV_CYCLES - 1);
  localparam logic [WDG_PULSE_W-1:0] WDG_PULSE_LAST = WDG_PULSE_W'(WDG_PULSE_CYCLES - 1);
  typedef enum logic [1:0] {
    WDG_RUN   = 2'h0,
    WDG_WAIT  = 2'h1,
    WDG_STOP  = 2'h2
  } wdg_power_e;
endpackage

// ---- rtl/wdg_sync.sv ----
// Three-stage synchroniser for pin inputs with agreement filter
`timescale 1ns/10ps
`default_nettype none
module wdg_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pin,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      // Only a change seen by both later stages counts
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule
`default_nettype wire

// ---- rtl/wdg_pulse.sv ----
// Fixed-length reset pulse generator
`timescale 1ns/10ps
`default_nettype none
module wdg_pulse (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic trigger,
  output logic      rst_out_n
);
  import wdg_pkg::*;
  logic [WDG_PULSE_W-1:0] count;
  logic                   busy;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy  <= 1'b0;
      count <= '0;
    end else if (trigger && !busy) begin
      busy  <= 1'b1;
      // Start at one so the output stays low for exactly the pulse count
      count <= WDG_PULSE_W'(1);
    end else if (busy) begin
      // Fixed cycle count approximates the nominal width; see [RULE_20]
      if (count == WDG_PULSE_LAST) begin
        busy <= 1'b0;
      end
      count <= count + 1'b1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_out_n <= 1'b1;
    end else begin
      rst_out_n <= !(busy || (trigger && !busy));
    end
  end
endmodule
`default_nettype wire

// ---- tb/wdg_chk_assertions.sv ----
// Port checker for the watchdog block
`timescale 1ns/10ps
`default_nettype none
module wdg_chk
  import wdg_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        stop_control_option,
  input wire logic        stop_request,
  input wire logic        stop_enter,
  input wire logic        wait_enter,
  input wire logic        wdg_reset_n,
  input wire logic        hw_active
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       wr_d;
  logic [6:0] low_n;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_d  <= 1'b0;
      low_n <= 7'h00;
    end else begin
      wr_d  <= hsel && htrans[1] && hwrite && haddr == WDG_ADDR_TIMEOUT;
      low_n <= wdg_reset_n ? 7'h00 : low_n + 7'h01;
    end
  end
  property p_pulse; $rose(wdg_reset_n) |-> low_n == 7'(WDG_PULSE_CYCLES); endproperty
  a_pulse: assert property (p_pulse) else $error("pulse length");
  property p_swrst; wr_d && !hwdata[1] && (hwdata[0] || hw_active) |-> ##[1:4] !wdg_reset_n; endproperty
  a_swrst: assert property (p_swrst) else $error("no soft reset");
  property p_cause; $fell(wdg_reset_n) |-> hw_active; endproperty
  a_cause: assert property (p_cause) else $error("reset while idle");
  property p_sticky; hw_active |=> hw_active; endproperty
  a_sticky: assert property (p_sticky) else $error("activation lost");
  property p_excl; !(stop_enter && wait_enter); endproperty
  a_excl: assert property (p_excl) else $error("stop and wait");
  property p_idle; !stop_request [*3] |-> !stop_enter && !wait_enter; endproperty
  a_idle: assert property (p_idle) else $error("low power without request");
  property p_stopopt; stop_enter && hw_active |-> stop_control_option; endproperty
  a_stopopt: assert property (p_stopopt) else $error("stop not waited");
  property p_rdhi; hrdata[31:8] == 24'h000000 && !hresp; endproperty
  a_rdhi: assert property (p_rdhi) else $error("upper read bits");
  c_stop: cover property (stop_enter);
  c_wait: cover property (wait_enter);
  c_rst: cover property ($fell(wdg_reset_n));
endmodule
bind wdg_top wdg_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata), .hresp(hresp), .stop_control_option(stop_control_option),
  .stop_request(stop_request), .stop_enter(stop_enter), .wait_enter(wait_enter), .wdg_reset_n(wdg_reset_n),
  .hw_active(hw_active));
`default_nettype wire

// ---- tb/watchdog_timer_softreset_tb_top.sv ----
// Self-checking testbench for the watchdog block
`timescale 1ns/10ps
`default_nettype none
module watchdog_timer_softreset_tb_top;
  import wdg_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, act_opt = 1'b0, stp_opt = 1'b0, nmi = 1'b0, sreq = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic        hreadyout, hresp, stop_enter, wait_enter, wdg_reset_n, hw_active;
  int          err_total = 0, n_tests = 0, cyc = 0, t0, n;
  wdg_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(WDG_HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .activation_option(act_opt), .stop_control_option(stp_opt), .nmi_pin(nmi),
    .stop_request(sreq), .stop_enter(stop_enter), .wait_enter(wait_enter), .wdg_reset_n(wdg_reset_n),
    .hw_active(hw_active));
  always #4 hclk = ~hclk;
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Falling edge, so interval readings taken at rising edges never race it
  always @(negedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      close_out;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    n_tests++;
    if (v !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, v);
    end
  endtask
  // Called at a rising edge; each phase held until hready is seen high
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    htrans <= WDG_HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // Back-to-back reads keep a steady 2-cycle grid, so intervals come out exact
  task automatic poll(input logic [31:0] old);
    do bus(1'b0, WDG_ADDR_TIMEOUT, 32'h0); while (q === old);
  endtask
  function automatic logic [31:0] enc(input logic [6:0] c, input logic a);
    return {24'h0, c[0], c[1], c[2], c[3], c[4], c[5], c[6], a};
  endfunction
  task automatic lp(input logic o, input logic p, input logic es, input logic ew);
    stp_opt <= o;
    nmi     <= p;
    repeat (6) @(posedge hclk);
    sreq <= 1'b1;
    repeat (4) @(posedge hclk);
    chk("stop", es, stop_enter);
    chk("wait", ew, wait_enter);
    sreq <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask
  task automatic wfor(input logic lv, input int lim);
    n = 0;
    while (wdg_reset_n !== lv && n < lim) begin
      @(posedge hclk);
      n++;
    end
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("active", 1'b0, hw_active);
    bus(1'b0, WDG_ADDR_TIMEOUT, 32'h0);
    chk("reset value", 32'hFE, q);
    bus(1'b0, 32'h0, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, WDG_ADDR_TIMEOUT, enc(7'h00, 1'b0));
    poll(enc(7'h00, 1'b0));
    t0 = cyc;
    chk("wrap", enc(7'h7F, 1'b0), q);
    poll(q);
    chk("decrement", enc(7'h7E, 1'b0), q);
    chk("interval", WDG_DIV_CYCLES, cyc - t0);
    chk("no reset", 1'b1, wdg_reset_n);
    lp(1'b0, 1'b1, 1'b1, 1'b0);
    bus(1'b1, WDG_ADDR_TIMEOUT, enc(7'h7E, 1'b1));
    // The activate bit lands at the edge that ends the write
    @(posedge hclk);
    chk("activated", 1'b1, hw_active);
    bus(1'b1, WDG_ADDR_TIMEOUT, enc(7'h7F, 1'b0));
    bus(1'b0, WDG_ADDR_TIMEOUT, 32'h0);
    chk("act kept", 1'b1, q[0]);
    lp(1'b0, 1'b1, 1'b0, 1'b1);
    lp(1'b1, 1'b1, 1'b1, 1'b0);
    lp(1'b1, 1'b0, 1'b0, 1'b1);
    bus(1'b1, WDG_ADDR_TIMEOUT, 32'hFD);
    wfor(1'b0, 5);
    t0 = cyc;
    chk("soft reset", 1'b1, n < 5);
    // Soft-reset bit set again, so the pulse ends after its fixed length
    bus(1'b1, WDG_ADDR_TIMEOUT, enc(7'h7E, 1'b1));
    wfor(1'b1, 100);
    chk("pulse length", WDG_PULSE_CYCLES, cyc - t0);
    // Chip reset with the hardware strap
    act_opt <= 1'b1;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("hw active", 1'b1, hw_active);
    bus(1'b1, WDG_ADDR_TIMEOUT, enc(7'h40, 1'b0));
    @(posedge hclk);
    chk("hw kept", 1'b1, hw_active);
    wfor(1'b0, 3200);
    // Minimum reload expires within one interval, plus the pulse start latency
    chk("expiry", 1'b1, n <= WDG_DIV_CYCLES + 2);
    close_out;
  end
endmodule
`default_nettype wire
